// *** rtl/socket_defines.svh ***
// constants of the bus socket handshake
`ifndef SOCKET_DEFINES_SVH
`define SOCKET_DEFINES_SVH

`define SOCK_DATA_W 32
`define SOCK_ADDR_W 32
`define SOCK_LANES 4
`define SOCK_LANE_W 8
`define SOCK_LANES_PER_DEC 2
`define SOCK_NUM_DEC 2
`define SOCK_BE_WORD 4'hF
`define SOCK_BE_HALF_LO 4'h3
`define SOCK_BE_HALF_HI 4'hC
`define SOCK_ST_IDLE 2'h1
`define SOCK_ST_WAIT 2'h2

`endif

// *** rtl/socket_pkg.sv ***
// types of the bus socket handshake
`include "socket_defines.svh"

package socket_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = `SOCK_ST_IDLE,
		ST_WAIT = `SOCK_ST_WAIT
	} socket_state_t;

	typedef logic [`SOCK_DATA_W-1:0] data_word_t;
	typedef logic [`SOCK_LANES-1:0] lane_mask_t;

	typedef struct packed {
		socket_state_t state;
		logic extend;
		logic wait_seen;
		logic bp_hit;
		logic rvalid;
		data_word_t rdata;
	} socket_regs_t;

endpackage

// *** rtl/range_decoder.sv ***
// one address decoder with two byte-lane selects
`timescale 1ns/1ns

module range_decoder #(
	parameter int ADDR_W = 32
) (
	// current bus access
	input wire logic access_valid_i,
	input wire logic access_write_i,
	input wire logic [ADDR_W-1:0] address_i,
	input wire logic [1:0] lane_enable_i,
	// configuration
	input wire logic [ADDR_W-1:0] base_i,
	input wire logic [ADDR_W-1:0] mask_i,
	input wire logic init_wait_en_i,
	// decode results
	output logic hit_o,
	output logic init_wait_o,
	output logic [1:0] read_lane_select_o,
	output logic [1:0] write_lane_select_o
);

	logic in_range;

	// only the own range is decoded
	assign in_range = access_valid_i && ((address_i & mask_i) == (base_i & mask_i));
	assign hit_o = in_range && (lane_enable_i != 2'h0);
	// one initial wait for both directions
	assign init_wait_o = hit_o && init_wait_en_i;
	assign write_lane_select_o = (in_range && access_write_i) ? lane_enable_i : 2'h0;
	assign read_lane_select_o = (in_range && !access_write_i) ? lane_enable_i : 2'h0;

endmodule

// *** rtl/socket_handshake.sv ***
// slave-side wait and breakpoint handshake of the fabric bus socket
`timescale 1ns/1ns

// Summary of operation
// - wait_seen_flag is high exactly when the last bus cycle without a breakpoint in force was a wait.
// - the first wait of an access always comes from a decoder.
// - a decoder adds its initial wait only for accesses to its own range.
// - wait_extend_request sampled high during a wait makes the following bus cycle a wait.
// - any number of extended waits accepted, no timeout.
// - breakpoint_hit goes high on unit or fabric breakpoint events.
// - bus-clocked fabric logic is stopped while a breakpoint is in force.
// - breakpoint force input causes a hardware breakpoint event.
// - decoder asserts write_lane_select for writes inside its range.
// - write select held through decoder and extend waits, dropped when the access ends or a breakpoint is in force.
// - read select held through decoder and extend waits, dropped after the final cycle or while a breakpoint is in force.
// - one cycle no wait, two cycles decoder wait, more adds extends.
// - decoder initial wait applies to reads and writes alike.
// - two read and two write lane selects per decoder, as byte enables.
// - narrow writes replicated across lanes, unselected read lanes are zero.
module socket_handshake
	import socket_pkg::*;
#(
	parameter int NUM_DEC = `SOCK_NUM_DEC,
	parameter int ADDR_W = `SOCK_ADDR_W
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// bus master side
	input wire logic access_valid_i,
	input wire logic access_write_i,
	input wire logic [ADDR_W-1:0] address_i,
	input wire socket_pkg::lane_mask_t byte_enable_i,
	input wire socket_pkg::data_word_t master_wdata_i,
	output logic bus_ready_o,
	output logic bus_wait_o,
	output socket_pkg::data_word_t bus_rdata_o,
	output logic bus_rvalid_o,
	// decoder configuration
	input wire logic [NUM_DEC*ADDR_W-1:0] dec_base_i,
	input wire logic [NUM_DEC*ADDR_W-1:0] dec_mask_i,
	input wire logic [NUM_DEC-1:0] dec_init_wait_en_i,
	// fabric side
	output logic [NUM_DEC*2-1:0] read_lane_select_o,
	output logic [NUM_DEC*2-1:0] write_lane_select_o,
	output socket_pkg::data_word_t fabric_wdata_o,
	input wire socket_pkg::data_word_t fabric_rdata_i,
	input wire logic wait_extend_request_i,
	output logic wait_seen_flag_o,
	// breakpoint
	input wire logic bp_unit_event_i,
	input wire logic breakpoint_force_i,
	output logic breakpoint_hit_o,
	output logic fabric_run_o
);

	socket_regs_t cur_q;
	socket_regs_t nxt_d;

	logic [NUM_DEC-1:0] dec_hit;
	logic [NUM_DEC-1:0] dec_init_wait;
	logic [NUM_DEC*2-1:0] rd_sel;
	logic [NUM_DEC*2-1:0] wr_sel;
	logic any_hit;
	logic any_init_wait;
	logic first_cycle;
	logic wait_now;
	logic frozen;
	data_word_t rd_masked;

	// the lane selects must cover the data bus exactly
	initial begin
		if (NUM_DEC * `SOCK_LANES_PER_DEC != `SOCK_LANES) begin
			$error("NUM_DEC must give one select per byte lane");
		end
		if (ADDR_W < 1) begin
			$error("ADDR_W must be positive");
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DEC; gi = gi + 1) begin : g_dec
			range_decoder #(
				.ADDR_W(ADDR_W)
			) u_dec (
				.access_valid_i(access_valid_i),
				.access_write_i(access_write_i),
				.address_i(address_i),
				.lane_enable_i(byte_enable_i[gi*2 +: 2]),
				.base_i(dec_base_i[gi*ADDR_W +: ADDR_W]),
				.mask_i(dec_mask_i[gi*ADDR_W +: ADDR_W]),
				.init_wait_en_i(dec_init_wait_en_i[gi]),
				.hit_o(dec_hit[gi]),
				.init_wait_o(dec_init_wait[gi]),
				.read_lane_select_o(rd_sel[gi*2 +: 2]),
				.write_lane_select_o(wr_sel[gi*2 +: 2])
			);
		end
	endgenerate

	assign any_hit = |dec_hit;
	assign any_init_wait = |dec_init_wait;

	// a breakpoint in force freezes the socket with the system
	assign frozen = cur_q.bp_hit;

	// first cycle of an access: the last cycle without a breakpoint in force was no wait
	assign first_cycle = (cur_q.state == ST_IDLE);

	// current cycle wait: decoder first, fabric extends after
	always_comb begin
		wait_now = 1'b0;
		if (any_hit) begin
			if (first_cycle) begin
				wait_now = any_init_wait;
			end else begin
				wait_now = cur_q.extend;
			end
		end
	end

	// replicate narrow write data across all lanes
	function automatic data_word_t replicate(input data_word_t wd, input lane_mask_t be);
		data_word_t r;
		r = wd;
		case (be)
			`SOCK_BE_WORD: r = wd;
			`SOCK_BE_HALF_LO: r = {wd[15:0], wd[15:0]};
			`SOCK_BE_HALF_HI: r = {wd[31:16], wd[31:16]};
			4'h1: r = {4{wd[7:0]}};
			4'h2: r = {4{wd[15:8]}};
			4'h4: r = {4{wd[23:16]}};
			4'h8: r = {4{wd[31:24]}};
			default: r = wd;
		endcase
		return r;
	endfunction

	assign fabric_wdata_o = replicate(master_wdata_i, byte_enable_i);

	// unselected read lanes read as zero
	genvar li;
	generate
		for (li = 0; li < `SOCK_LANES; li = li + 1) begin : g_lane
			assign rd_masked[li*`SOCK_LANE_W +: `SOCK_LANE_W] =
				rd_sel[li] ? fabric_rdata_i[li*`SOCK_LANE_W +: `SOCK_LANE_W] : 8'h00;
		end
	endgenerate

	// selects stay up through decoder and extend waits until the final cycle; a breakpoint in force drops them to zero
	assign read_lane_select_o = frozen ? '0 : rd_sel;
	assign write_lane_select_o = frozen ? '0 : wr_sel;

	// master handshake: ready on the final cycle of a hit access
	assign bus_wait_o = frozen || wait_now;
	assign bus_ready_o = !frozen && access_valid_i && any_hit && !wait_now;

	always_comb begin
		nxt_d = cur_q;
		nxt_d.rvalid = 1'b0;
		nxt_d.bp_hit = bp_unit_event_i || breakpoint_force_i;
		if (!frozen) begin
			nxt_d.wait_seen = wait_now;
			// extension only counts inside an access already waiting
			nxt_d.extend = wait_extend_request_i && any_hit && wait_now;
			if (wait_now) begin
				// no timeout: stays here as long as extends arrive
				nxt_d.state = ST_WAIT;
			end else begin
				nxt_d.state = ST_IDLE;
			end
			if (access_valid_i && any_hit && !wait_now && !access_write_i) begin
				nxt_d.rdata = rd_masked;
				nxt_d.rvalid = 1'b1;
			end
		end
		case (cur_q.state)
			ST_IDLE: begin
			end
			ST_WAIT: begin
			end
			default: begin
				nxt_d.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cur_q.state <= ST_IDLE;
			cur_q.extend <= 1'b0;
			cur_q.wait_seen <= 1'b0;
			cur_q.bp_hit <= 1'b0;
			cur_q.rvalid <= 1'b0;
			cur_q.rdata <= 32'h0000_0000;
		end else begin
			cur_q <= nxt_d;
		end
	end

	assign wait_seen_flag_o = cur_q.wait_seen;
	assign breakpoint_hit_o = cur_q.bp_hit;
	assign fabric_run_o = !cur_q.bp_hit;
	assign bus_rdata_o = cur_q.rdata;
	assign bus_rvalid_o = cur_q.rvalid;

endmodule

// *** testbench/socket_checker.sv ***
// port assertions of the socket handshake
`timescale 1ns/1ns
module socket_checker
	import socket_pkg::*;
#(
	parameter int NUM_DEC = 2,
	parameter int ADDR_W = 32
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic access_valid_i,
	input wire logic access_write_i,
	input wire socket_pkg::lane_mask_t byte_enable_i,
	input wire socket_pkg::data_word_t master_wdata_i,
	input wire logic [NUM_DEC-1:0] dec_init_wait_en_i,
	input wire logic wait_extend_request_i,
	input wire logic bp_unit_event_i,
	input wire logic breakpoint_force_i,
	input wire logic bus_ready_o,
	input wire logic bus_wait_o,
	input wire logic [NUM_DEC*2-1:0] read_lane_select_o,
	input wire logic [NUM_DEC*2-1:0] write_lane_select_o,
	input wire socket_pkg::data_word_t fabric_wdata_o,
	input wire logic wait_seen_flag_o,
	input wire logic breakpoint_hit_o,
	input wire logic fabric_run_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	wire sel = |{read_lane_select_o, write_lane_select_o};
	property p_seen; !breakpoint_hit_o |=> wait_seen_flag_o == $past(bus_wait_o); endproperty
	a_seen: assert property (p_seen) else $error("wait seen flag mismatch");
	property p_first;
		access_valid_i && !wait_seen_flag_o && dec_init_wait_en_i == '0 && !breakpoint_hit_o |-> !bus_wait_o;
	endproperty
	a_first: assert property (p_first) else $error("first wait without decoder");
	property p_range; bus_wait_o && !breakpoint_hit_o |-> access_valid_i && sel; endproperty
	a_range: assert property (p_range) else $error("wait outside own range");
	property p_ext;
		wait_extend_request_i && bus_wait_o && access_valid_i && !breakpoint_hit_o |=> bus_wait_o;
	endproperty
	a_ext: assert property (p_ext) else $error("extend not honoured");
	property p_bp; 1 |=> breakpoint_hit_o == ($past(bp_unit_event_i) || $past(breakpoint_force_i)); endproperty
	a_bp: assert property (p_bp) else $error("breakpoint hit mismatch");
	property p_freeze; breakpoint_hit_o |-> !fabric_run_o && !bus_ready_o && bus_wait_o && !sel; endproperty
	a_freeze: assert property (p_freeze) else $error("not frozen on breakpoint");
	property p_hold;
		bus_wait_o && !breakpoint_hit_o |=> breakpoint_hit_o || $stable(read_lane_select_o) && $stable(write_lane_select_o);
	endproperty
	a_hold: assert property (p_hold) else $error("select moved during wait");
	property p_drop; bus_ready_o ##1 !access_valid_i |-> !sel; endproperty
	a_drop: assert property (p_drop) else $error("select kept after access");
	property p_repl;
		access_valid_i && access_write_i && byte_enable_i == 4'hC |-> fabric_wdata_o == {2{master_wdata_i[31:16]}};
	endproperty
	a_repl: assert property (p_repl) else $error("half word not replicated");
	c_ext: cover property (wait_extend_request_i && bus_wait_o);
	c_bp: cover property (breakpoint_hit_o);
	c_end: cover property (bus_ready_o && wait_seen_flag_o);
endmodule
bind socket_handshake socket_checker #(.NUM_DEC(NUM_DEC), .ADDR_W(ADDR_W)) socket_checker_i (.*);

// *** testbench/fabric_model.sv ***
// fabric register function with a chosen number of extra waits
`timescale 1ns/1ns
module fabric_model (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic [3:0] rd_sel_i,
	input wire logic [3:0] wr_sel_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] n_ext_i,
	input wire logic stray_i,
	output logic [31:0] rdata_o,
	output logic extend_o
);
	logic [31:0] data_q;
	logic [3:0] cnt_q;
	wire sel = |{rd_sel_i, wr_sel_i};
	assign extend_o = stray_i | (sel && cnt_q < n_ext_i);
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			data_q <= '0;
			cnt_q <= '0;
		end else if (run_i) begin
			cnt_q <= sel ? cnt_q + 4'h1 : 4'h0;
			for (int i = 0; i < 4; i++) begin
				if (wr_sel_i[i]) data_q[8*i+:8] <= wdata_i[8*i+:8];
			end
		end
	end
	// released lanes show the inverse, never a stale value
	always_comb begin
		for (int i = 0; i < 4; i++) rdata_o[8*i+:8] = rd_sel_i[i] ? data_q[8*i+:8] : ~data_q[8*i+:8];
	end
endmodule

// *** testbench/socket_handshake_tb.sv ***
// self-checking bench of the socket handshake
`timescale 1ns/1ns
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("wrong value %s exp %h got %h", n, e, a); end end
module socket_handshake_tb;
	import socket_pkg::*;
	typedef struct packed {logic wr; lane_mask_t be; data_word_t wd; logic iw; logic [3:0] ne; data_word_t rd;} row_t;
	logic clock_i, resetn_i, access_valid_i, access_write_i, bus_ready_o, bus_wait_o, bus_rvalid_o;
	logic [31:0] address_i;
	lane_mask_t byte_enable_i;
	data_word_t master_wdata_i, bus_rdata_o, fabric_wdata_o, fabric_rdata_i;
	logic [63:0] dec_base_i, dec_mask_i;
	logic [1:0] dec_init_wait_en_i;
	logic [3:0] read_lane_select_o, write_lane_select_o, n_ext;
	logic wait_extend_request_i, wait_seen_flag_o, bp_unit_event_i, breakpoint_force_i, breakpoint_hit_o, fabric_run_o, stray;
	int miscompares, n_compared, waits, k;
	row_t rows[6] = '{'{1'b1, 4'hF, 32'hFFFFFFFF, 1'b0, 4'h0, 32'h0}, '{1'b1, 4'hC, 32'h0, 1'b1, 4'h0, 32'h0},
		'{1'b1, 4'h8, 32'hFF000000, 1'b1, 4'h2, 32'h0}, '{1'b0, 4'h8, 32'h0, 1'b1, 4'h1, 32'hFF000000},
		'{1'b0, 4'h3, 32'h0, 1'b0, 4'h0, 32'h0000FFFF}, '{1'b0, 4'hF, 32'h0, 1'b1, 4'h3, 32'hFF00FFFF}};
	assign dec_base_i = {2{32'h00001000}};
	assign dec_mask_i = {2{32'hFFFFFFFC}};
	socket_handshake socket_handshake_i (.*);
	fabric_model fabric_model_i (.clock_i, .resetn_i, .run_i(fabric_run_o), .rd_sel_i(read_lane_select_o),
		.wr_sel_i(write_lane_select_o), .wdata_i(fabric_wdata_o), .n_ext_i(n_ext), .stray_i(stray),
		.rdata_o(fabric_rdata_i), .extend_o(wait_extend_request_i));
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end
	task automatic end_sim();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic acc(input row_t r);
		access_valid_i = 1'b1;
		access_write_i = r.wr;
		address_i = 32'h00001000;
		byte_enable_i = r.be;
		master_wdata_i = r.wd;
		dec_init_wait_en_i = {2{r.iw}};
		n_ext = r.ne;
		waits = 0;
		#1;
		`CHK("select", r.be, r.wr ? write_lane_select_o : read_lane_select_o)
		while (!bus_ready_o && waits < 40) begin
			waits++;
			@(negedge clock_i);
			#1;
		end
		`CHK("waits", r.iw + r.ne, waits)
		`CHK("seen", r.iw | (r.ne != 0), wait_seen_flag_o)
		@(negedge clock_i);
		access_valid_i = 1'b0;
		#1;
		if (!r.wr) `CHK("rdata", {1'b1, r.rd}, {bus_rvalid_o, bus_rdata_o})
		@(negedge clock_i);
	endtask
	initial begin
		{resetn_i, access_valid_i, access_write_i, address_i, byte_enable_i, master_wdata_i} = '0;
		{dec_init_wait_en_i, n_ext, bp_unit_event_i, breakpoint_force_i, stray} = '0;
		repeat (8) @(negedge clock_i);
		`CHK("reset", 4'h1, {breakpoint_hit_o, wait_seen_flag_o, bus_rvalid_o, fabric_run_o})
		resetn_i = 1'b1;
		@(negedge clock_i);
		foreach (rows[i]) acc(rows[i]);
		stray = 1'b1;
		acc('{1'b1, 4'hF, 32'h12345678, 1'b0, 4'h0, 32'h0});
		access_valid_i = 1'b1;
		address_i = 32'h00002000;
		dec_init_wait_en_i = 2'h3;
		repeat (2) begin
			#1;
			`CHK("stray", 10'h0, {bus_wait_o, bus_ready_o, read_lane_select_o, write_lane_select_o})
			@(negedge clock_i);
		end
		{access_valid_i, stray} = '0;
		for (k = 1; k < 3; k++) begin
			{bp_unit_event_i, breakpoint_force_i} = k[1:0];
			@(negedge clock_i);
			`CHK("halt", 2'h2, {breakpoint_hit_o, fabric_run_o})
			{bp_unit_event_i, breakpoint_force_i} = 2'h0;
			@(negedge clock_i);
			`CHK("resume", 2'h1, {breakpoint_hit_o, fabric_run_o})
		end
		end_sim();
	end
	initial begin
		#20000;
		miscompares++;
		end_sim();
	end
endmodule
